// ---- cfs_params.svh ----
// Constants for the core architectural state block
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH

// Vectors: high byte at the even address, low byte at the odd one
`define CFS_VEC_RESET    16'hfffe
`define CFS_VEC_TRAP     16'hfffc
`define CFS_VEC_IRQ0     16'hfffa

// Push-pop pointer: upper nine bits fixed, low seven bits float
`define CFS_SP_RESET     16'h017f
`define CFS_SP_FIXED     9'h002
`define CFS_SPL_TOP      7'h7f

// Flag word reset value and bit positions
`define CFS_CC_RESET     8'he8
`define CFS_CC_ONES      8'he0
`define CFS_CC_H         4
`define CFS_CC_I         3
`define CFS_CC_N         2
`define CFS_CC_Z         1
`define CFS_CC_C         0

// Option byte bit that disables the undervoltage reset
`define CFS_OPT_UV_OFF   3

// Start-up hold in CPU clock cycles
`define CFS_HOLD_CYCLES  13'd4096

// Context sizes in stack bytes, minus one
`define CFS_CALL_LAST    3'd1
`define CFS_CTX_LAST     3'd4

`endif

// ---- cfs_pkg.sv ----
// Types for the core architectural state block
package cfs_pkg;

	// Micro-operations from the execution unit
	typedef enum logic [4:0] {
		CFS_OP_NOP     = 5'h00,
		CFS_OP_WR_A    = 5'h01,
		CFS_OP_WR_X    = 5'h02,
		CFS_OP_WR_Y    = 5'h03,
		CFS_OP_WR_PC   = 5'h04,
		CFS_OP_INC_PC  = 5'h05,
		CFS_OP_ADD     = 5'h06,
		CFS_OP_ADC     = 5'h07,
		CFS_OP_RESULT  = 5'h08,
		CFS_OP_SHIFT   = 5'h09,
		CFS_OP_BIT_BR  = 5'h0a,
		CFS_OP_CARRY_S = 5'h0b,
		CFS_OP_CARRY_C = 5'h0c,
		CFS_OP_MASK_S  = 5'h0d,
		CFS_OP_MASK_C  = 5'h0e,
		CFS_OP_SP_RST  = 5'h0f,
		CFS_OP_WR_SPL  = 5'h10,
		CFS_OP_WR_CC   = 5'h11,
		CFS_OP_CALL    = 5'h12,
		CFS_OP_RET     = 5'h13,
		CFS_OP_HANDLER_RETURN_OP    = 5'h14,
		CFS_OP_TRAP    = 5'h15
	} cfs_op_t;

	// Sequencer states, one-hot
	typedef enum logic [7:0] {
		CFS_HOLD    = 8'h01,
		CFS_VEC_HI  = 8'h02,
		CFS_VEC_LO  = 8'h04,
		CFS_VEC_END = 8'h08,
		CFS_RUN     = 8'h10,
		CFS_PUSH    = 8'h20,
		CFS_POP_RD  = 8'h40,
		CFS_POP_CAP = 8'h80
	} cfs_state_t;

	// Complete state of the core block
	typedef struct packed {
		cfs_state_t  st;
		logic [7:0]  a;
		logic [7:0]  x;
		logic [7:0]  y;
		logic [15:0] pc;
		logic [7:0]  cc;
		logic [6:0]  spl;
		logic [7:0]  pend;
		logic [12:0] hold;
		logic [15:0] vec;
		logic [2:0]  idx;
		logic [2:0]  last;
		logic        irq;
		logic        handler_return_op;
		logic [15:0] paddr;
		logic        prd;
		logic        rst_drv;
	} cfs_core_t;

	// State of the stack memory
	typedef struct packed {
		logic [127:0][7:0] mem;
		logic [7:0]        rdata;
	} cfs_mem_t;

endpackage

// ---- cfs_stack_mem.sv ----
// Stack memory, 128 bytes, registered read data
`timescale 1ns/10ps
module cfs_stack_mem
	import cfs_pkg::*;
(
	// Clock, reset, enable
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	// Access port
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic [6:0] addr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o
);

	cfs_mem_t r;       // Registered state
	cfs_mem_t next_r;  // Next state

	// ************************************************
	// Write and read decode
	// ************************************************
	always_comb begin
		next_r = r;
		if (wr_i) begin
			next_r.mem[addr_i] = wdata_i;
		end
		if (rd_i) begin
			next_r.rdata = r.mem[addr_i];
		end
	end

	// ************************************************
	// State register; contents survive reset
	// ************************************************
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			r <= '{mem: r.mem, rdata: 8'h00};
		end else if (ce_i) begin
			r <= next_r;
		end
	end

	assign rdata_o = r.rdata;

endmodule

// ---- cfs_core_state.sv ----
// Core architectural state: registers, flags, stack, reset sequencing
`timescale 1ns/10ps
`include "cfs_params.svh"
// Behaviour
// - Result store plus two 8-bit index registers
// - Second index register never saved or restored
// - Sixteen-bit fetch pointer from two byte halves
// - Add sets nibble carry from bit three
// - Mask flag set on entry, cleared by handler return
// - Masked requests stay pending until unmasked
// - Clearing mask in handler takes pending at the next instruction end
// - Sign flag copies result bit seven
// - Zero flag set on zero result
// - Carry flag from arithmetic, set/clear, shifts
// - Pointer post-decrement push, pre-increment pop
// - Upper nine pointer bits forced, restore sets low
// - Pointer wraps silently at both limits
// - Pointer low byte loadable and readable
// - Fetch pointer low byte pushed first
// - Reset loads vector from top two addresses
// - Hold core 4096 cycles after start
// - Three reset sources; undervoltage drives pin low
// - Option bit three disables undervoltage reset
module cfs_core_state
	import cfs_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// Reset sources and option byte
	input  wire logic        reset_pin_i,
	input  wire logic        wdg_reset_i,
	input  wire logic        uv_detect_i,
	input  wire logic [7:0]  option_byte_i,
	output logic             reset_pin_o,
	output logic             reset_pin_oe_o,
	// Micro-operation port
	input  wire logic        op_valid_i,
	input  wire cfs_op_t     op_code_i,
	input  wire logic [7:0]  op_data_i,
	input  wire logic [15:0] op_addr_i,
	input  wire logic        op_carry_i,
	input  wire logic        instr_end_i,
	output logic             busy_o,
	// Interrupt requests, bit 0 highest priority
	input  wire logic [7:0]  irq_req_i,
	output logic [7:0]       irq_pend_o,
	// Program memory read port for vectors
	output logic             prog_rd_o,
	output logic [15:0]      prog_addr_o,
	input  wire logic [7:0]  prog_data_i,
	// Architectural state
	output logic [7:0]       acc_o,
	output logic [7:0]       idx_x_o,
	output logic [7:0]       idx_y_o,
	output logic [15:0]      next_fetch_pointer_o,
	output logic [7:0]       flag_word_o,
	output logic [15:0]      push_pop_pointer_o
);

	cfs_core_t r;        // Registered state
	cfs_core_t next_r;   // Next state
	logic      src_rst;  // Any reset source active
	logic      uv_rst;   // Undervoltage reset active
	logic      mem_wr;   // Stack write strobe
	logic      mem_rd;   // Stack read strobe
	logic [6:0] mem_addr; // Stack byte address
	logic [7:0] mem_wdata; // Stack write byte
	logic [7:0] mem_rdata; // Stack read byte

	// ************************************************
	// Helper functions
	// ************************************************

	// Sign and zero flags from a result
	function automatic logic [7:0] set_nz(input logic [7:0] cc, input logic [7:0] res);
		logic [7:0] f;
		f = cc;
		f[`CFS_CC_N] = res[7];
		f[`CFS_CC_Z] = (res == 8'h00);
		return f;
	endfunction

	// Context byte by push index
	function automatic logic [7:0] ctx_byte(input cfs_core_t s, input logic [2:0] i);
		logic [7:0] b;
		b = 8'h00;
		case (i)
			3'd0: b = s.pc[7:0];
			3'd1: b = s.pc[15:8];
			3'd2: b = s.x;
			3'd3: b = s.a;
			3'd4: b = s.cc;
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	// ************************************************
	// Reset sources
	// ************************************************
	always_comb begin
		// Undervoltage source gated by option bit
		uv_rst = uv_detect_i & ~option_byte_i[`CFS_OPT_UV_OFF];
		// Pin, watchdog and undervoltage
		src_rst = ~reset_pin_i | wdg_reset_i | uv_rst;
	end

	// ************************************************
	// Stack memory
	// ************************************************
	cfs_stack_mem u_stack (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.wr_i    (mem_wr),
		.rd_i    (mem_rd),
		.addr_i  (mem_addr),
		.wdata_i (mem_wdata),
		.rdata_o (mem_rdata)
	);

	// ************************************************
	// Next-state logic
	// ************************************************
	always_comb begin
		logic [8:0] sum;
		logic [4:0] nib;
		logic       cin;
		logic [2:0] win;
		logic       take;
		sum = 9'h000;
		nib = 5'h00;
		cin = 1'b0;
		win = 3'd0;
		take = 1'b0;
		next_r = r;
		mem_wr = 1'b0;
		mem_rd = 1'b0;
		mem_addr = r.spl;
		mem_wdata = 8'h00;
		next_r.prd = 1'b0;
		// Latch every request, set wins over clear
		next_r.pend = r.pend | irq_req_i;
		// Pin driven low during undervoltage or watchdog reset
		next_r.rst_drv = uv_rst | wdg_reset_i;
		// Highest priority pending request
		for (int i = 7; i >= 0; i--) begin
			if (r.pend[i]) begin
				win = 3'(i);
			end
		end
		case (r.st)
			// Start-up delay
			CFS_HOLD: begin
				if (r.hold == `CFS_HOLD_CYCLES - 13'd1) begin
					next_r.st = CFS_VEC_HI;
					next_r.vec = `CFS_VEC_RESET;
				end else begin
					next_r.hold = r.hold + 13'd1;
				end
			end
			// Read vector high byte
			CFS_VEC_HI: begin
				next_r.prd = 1'b1;
				next_r.paddr = r.vec;
				next_r.st = CFS_VEC_LO;
			end
			// Capture high byte, read low byte
			CFS_VEC_LO: begin
				next_r.pc[15:8] = prog_data_i;
				next_r.prd = 1'b1;
				next_r.paddr = r.vec + 16'h0001;
				next_r.st = CFS_VEC_END;
			end
			// Capture low byte and start execution
			CFS_VEC_END: begin
				next_r.pc[7:0] = prog_data_i;
				next_r.st = CFS_RUN;
			end
			// Push one context byte per cycle
			CFS_PUSH: begin
				mem_wr = 1'b1;
				mem_wdata = ctx_byte(r, r.idx);
				// Post-decrement, wraps silently
				next_r.spl = r.spl - 7'd1;
				next_r.idx = r.idx + 3'd1;
				if (r.idx == r.last) begin
					if (r.irq) begin
						// Mask on interrupt entry
						next_r.cc[`CFS_CC_I] = 1'b1;
						next_r.st = CFS_VEC_HI;
					end else begin
						next_r.pc = r.vec;
						next_r.st = CFS_RUN;
					end
				end
			end
			// Pre-increment and read
			CFS_POP_RD: begin
				next_r.spl = r.spl + 7'd1;
				mem_rd = 1'b1;
				mem_addr = r.spl + 7'd1;
				next_r.st = CFS_POP_CAP;
			end
			// Place popped byte, reverse order
			CFS_POP_CAP: begin
				case (r.idx)
					3'd0: next_r.pc[7:0] = mem_rdata;
					3'd1: next_r.pc[15:8] = mem_rdata;
					3'd2: next_r.x = mem_rdata;
					3'd3: next_r.a = mem_rdata;
					3'd4: next_r.cc = mem_rdata | `CFS_CC_ONES;
					default: next_r.a = r.a;
				endcase
				if (r.idx == 3'd0) begin
					// Handler return clears mask
					if (r.handler_return_op) begin
						next_r.cc[`CFS_CC_I] = 1'b0;
					end
					next_r.st = CFS_RUN;
				end else begin
					next_r.idx = r.idx - 3'd1;
					next_r.st = CFS_POP_RD;
				end
			end
			// Execute micro-operations
			CFS_RUN: begin
				if (op_valid_i) begin
					case (op_code_i)
						CFS_OP_WR_A: next_r.a = op_data_i;
						CFS_OP_WR_X: next_r.x = op_data_i;
						CFS_OP_WR_Y: next_r.y = op_data_i;
						CFS_OP_WR_PC: next_r.pc = op_addr_i;
						CFS_OP_INC_PC: next_r.pc = r.pc + 16'h0001;
						// Add and add with carry
						CFS_OP_ADD, CFS_OP_ADC: begin
							cin = (op_code_i == CFS_OP_ADC) & r.cc[`CFS_CC_C];
							sum = {1'b0, r.a} + {1'b0, op_data_i} + {8'h00, cin};
							nib = {1'b0, r.a[3:0]} + {1'b0, op_data_i[3:0]} + {4'h0, cin};
							next_r.a = sum[7:0];
							next_r.cc = set_nz(r.cc, sum[7:0]);
							next_r.cc[`CFS_CC_H] = nib[4];
							next_r.cc[`CFS_CC_C] = sum[8];
						end
						// Logic or data manipulation result
						CFS_OP_RESULT: begin
							next_r.a = op_data_i;
							next_r.cc = set_nz(r.cc, op_data_i);
						end
						// Shift or rotate result with carry out
						CFS_OP_SHIFT: begin
							next_r.a = op_data_i;
							next_r.cc = set_nz(r.cc, op_data_i);
							next_r.cc[`CFS_CC_C] = op_carry_i;
						end
						CFS_OP_BIT_BR: next_r.cc[`CFS_CC_C] = op_carry_i;
						CFS_OP_CARRY_S: next_r.cc[`CFS_CC_C] = 1'b1;
						CFS_OP_CARRY_C: next_r.cc[`CFS_CC_C] = 1'b0;
						CFS_OP_MASK_S: next_r.cc[`CFS_CC_I] = 1'b1;
						CFS_OP_MASK_C: next_r.cc[`CFS_CC_I] = 1'b0;
						CFS_OP_SP_RST: next_r.spl = `CFS_SPL_TOP;
						CFS_OP_WR_SPL: next_r.spl = op_data_i[6:0];
						CFS_OP_WR_CC: next_r.cc = op_data_i | `CFS_CC_ONES;
						// Subroutine call: two bytes, then target
						CFS_OP_CALL: begin
							next_r.vec = op_addr_i;
							next_r.idx = 3'd0;
							next_r.last = `CFS_CALL_LAST;
							next_r.irq = 1'b0;
							next_r.st = CFS_PUSH;
						end
						// Subroutine return
						CFS_OP_RET: begin
							next_r.idx = `CFS_CALL_LAST;
							next_r.handler_return_op = 1'b0;
							next_r.st = CFS_POP_RD;
						end
						// Handler return, index Y untouched
						CFS_OP_HANDLER_RETURN_OP: begin
							next_r.idx = `CFS_CTX_LAST;
							next_r.handler_return_op = 1'b1;
							next_r.st = CFS_POP_RD;
						end
						// Software break ignores the mask
						CFS_OP_TRAP: begin
							next_r.vec = `CFS_VEC_TRAP;
							next_r.idx = 3'd0;
							next_r.last = `CFS_CTX_LAST;
							next_r.irq = 1'b1;
							next_r.st = CFS_PUSH;
						end
						default: next_r.a = r.a;
					endcase
				end else if (instr_end_i & ~r.cc[`CFS_CC_I] & (|r.pend)) begin
					// Take pending request once unmasked
					take = 1'b1;
					next_r.vec = `CFS_VEC_IRQ0 - {12'h000, win, 1'b0};
					next_r.idx = 3'd0;
					next_r.last = `CFS_CTX_LAST;
					next_r.irq = 1'b1;
					next_r.st = CFS_PUSH;
				end
			end
			default: next_r.st = CFS_HOLD;
		endcase
		// Acknowledge the taken request; a new one wins
		if (take) begin
			next_r.pend = (r.pend & ~(8'h01 << win)) | irq_req_i;
		end
	end

	// ************************************************
	// State register
	// ************************************************
	always_ff @(posedge clock_i) begin
		if (rst_i | (ce_i & src_rst)) begin
			// Any reset source restarts the hold
			r <= '0;
			r.st <= CFS_HOLD;
			r.cc <= `CFS_CC_RESET;
			r.spl <= `CFS_SPL_TOP;
			r.vec <= `CFS_VEC_RESET;
			r.rst_drv <= ~rst_i & (uv_rst | wdg_reset_i);
		end else if (ce_i) begin
			r <= next_r;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	assign reset_pin_o          = 1'b0;
	assign reset_pin_oe_o       = r.rst_drv;
	assign busy_o               = (r.st != CFS_RUN);
	assign irq_pend_o           = r.pend;
	assign prog_rd_o            = r.prd;
	assign prog_addr_o          = r.paddr;
	assign acc_o                = r.a;
	assign idx_x_o              = r.x;
	assign idx_y_o              = r.y;
	assign next_fetch_pointer_o = r.pc;
	assign flag_word_o          = r.cc;
	// Upper bits forced
	assign push_pop_pointer_o   = {`CFS_SP_FIXED, r.spl};

endmodule

// ---- cfs_core_state_sva.sv ----
// Checker for the core architectural state block
`timescale 1ns/10ps
module cfs_core_state_sva
	import cfs_pkg::*;
(
	// Clock and reset
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	// Reset sources
	input wire logic        wdg_reset_i,
	input wire logic        uv_detect_i,
	input wire logic [7:0]  option_byte_i,
	input wire logic        reset_pin_o,
	input wire logic        reset_pin_oe_o,
	// Micro-operation and interrupt ports
	input wire logic        op_valid_i,
	input wire cfs_op_t     op_code_i,
	input wire logic [7:0]  op_data_i,
	input wire logic        instr_end_i,
	input wire logic        busy_o,
	input wire logic [7:0]  irq_req_i,
	input wire logic [7:0]  irq_pend_o,
	// Architectural state
	input wire logic [7:0]  acc_o,
	input wire logic [7:0]  idx_y_o,
	input wire logic [7:0]  flag_word_o,
	input wire logic [15:0] push_pop_pointer_o
);
	// ****************************************
	// Assertions
	// ****************************************
	logic take; // Op accepted this edge
	logic entry; // Interrupt entry taken this edge
	assign take = op_valid_i && ce_i && !busy_o;
	assign entry = instr_end_i && !op_valid_i && !flag_word_o[3] && irq_pend_o != 8'h00 && !busy_o;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	chk_pin_low_only: assert property (reset_pin_oe_o |-> !reset_pin_o
		&& $past(wdg_reset_i || uv_detect_i && !option_byte_i[3] || !ce_i))
		else $error("reset pin driven high or without a source");
	chk_ce_freeze: assert property (!ce_i |=> $stable(acc_o) && $stable(flag_word_o)
		&& $stable(push_pop_pointer_o))
		else $error("state changed while clock enable low");
	chk_uv_pin_drive: assert property (ce_i && uv_detect_i && !option_byte_i[3] |=> reset_pin_oe_o)
		else $error("undervoltage reset does not drive pin");
	chk_uv_disabled: assert property (ce_i && uv_detect_i && option_byte_i[3] && !busy_o
		|=> !busy_o)
		else $error("disabled undervoltage reset acted");
	chk_ptr_upper: assert property (push_pop_pointer_o[15:7] == 9'h002)
		else $error("pointer upper bits not fixed");
	chk_reset_state: assert property ($fell(rst_i) |->
		flag_word_o == 8'he8 && push_pop_pointer_o == 16'h017f)
		else $error("reset values wrong");
	chk_sp_restore: assert property (take && op_code_i == CFS_OP_SP_RST
		|=> push_pop_pointer_o == 16'h017f)
		else $error("pointer restore wrong");
	chk_add_flags: assert property (take && op_code_i == CFS_OP_ADD |=>
		flag_word_o[4] == ({1'b0, $past(acc_o[3:0])} + {1'b0, $past(op_data_i[3:0])} > 5'h0f)
		&& flag_word_o[1] == (acc_o == 8'h00) && flag_word_o[2] == acc_o[7])
		else $error("add flags wrong");
	chk_call_ptr: assert property (take && op_code_i == CFS_OP_CALL |=> busy_o ##1 busy_o
		##1 !busy_o && push_pop_pointer_o[6:0] == $past(push_pop_pointer_o[6:0], 3) - 7'd2)
		else $error("call stack use wrong");
	chk_irq_latch: assert property (irq_req_i[0] && flag_word_o[3] |=> irq_pend_o[0])
		else $error("masked request not latched");
	chk_entry_mask: assert property (entry |-> ##[1:10] flag_word_o[3])
		else $error("mask not set on entry");
	chk_y_kept: assert property (entry |=> $stable(idx_y_o) [*8])
		else $error("second index changed on entry");
endmodule
bind cfs_core_state cfs_core_state_sva chk_u (.clock_i, .rst_i, .ce_i, .wdg_reset_i, .uv_detect_i,
	.option_byte_i, .reset_pin_o, .reset_pin_oe_o, .op_valid_i, .op_code_i, .op_data_i,
	.instr_end_i, .busy_o, .irq_req_i, .irq_pend_o, .acc_o, .idx_y_o, .flag_word_o,
	.push_pop_pointer_o);

// ---- cfs_core_state_test.sv ----
// Self-checking testbench of the core architectural state block
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module cfs_core_state_test
	import cfs_pkg::*;
;
	// ****************************************
	// Stimulus and checks
	// ****************************************
	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        ce_i = 1'b1;
	logic        reset_pin_i = 1'b1;
	logic        wdg_reset_i = 1'b0;
	logic        uv_detect_i = 1'b0;
	logic [7:0]  option_byte_i = 8'h00;
	logic        reset_pin_o, reset_pin_oe_o, busy_o, prog_rd_o;
	logic        op_valid_i = 1'b0;
	cfs_op_t     op_code_i = CFS_OP_NOP;
	logic [7:0]  op_data_i = 8'h00;
	logic [15:0] op_addr_i = 16'h0000;
	logic        op_carry_i = 1'b0;
	logic        instr_end_i = 1'b0;
	logic [7:0]  irq_req_i = 8'h00;
	logic [7:0]  prog_data_i = 8'h00;
	logic [7:0]  irq_pend_o, acc_o, idx_x_o, idx_y_o, flag_word_o;
	logic [15:0] prog_addr_o, next_fetch_pointer_o, push_pop_pointer_o;
	int          error_cnt = 0;
	int          comparisons = 0;
	cfs_core_state dut_u (.clock_i, .rst_i, .ce_i, .reset_pin_i, .wdg_reset_i, .uv_detect_i,
		.option_byte_i, .reset_pin_o, .reset_pin_oe_o, .op_valid_i, .op_code_i, .op_data_i,
		.op_addr_i, .op_carry_i, .instr_end_i, .busy_o, .irq_req_i, .irq_pend_o, .prog_rd_o,
		.prog_addr_o, .prog_data_i, .acc_o, .idx_x_o, .idx_y_o, .next_fetch_pointer_o,
		.flag_word_o, .push_pop_pointer_o);
	// Clock, 8 ns period
	initial begin
		forever #4 clock_i = ~clock_i;
	end
	// Program memory: byte equals address low byte while read strobe is high
	always @(negedge clock_i) begin
		prog_data_i <= prog_rd_o ? prog_addr_o[7:0] : 8'h00;
	end
	// Verdict and end of run
	task automatic stop_test();
		if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Wait for the sequencer to return to run, counting busy cycles
	task automatic wait_ready(output int n);
		n = 0;
		while (busy_o !== 1'b0 && n < 5000) begin
			@(negedge clock_i);
			n++;
		end
		`CHK(busy_o, 1'b0)
	endtask
	// One micro-operation pulse
	task automatic op(input cfs_op_t c, input logic [7:0] d, input logic [15:0] a);
		@(negedge clock_i);
		op_valid_i = 1'b1;
		op_code_i = c;
		op_data_i = d;
		op_addr_i = a;
		@(negedge clock_i);
		op_valid_i = 1'b0;
	endtask
	// Reset, start-up hold and reset vector fetch
	task automatic t_reset();
		int n;
		repeat (6) @(negedge clock_i);
		`CHK(flag_word_o, 8'he8)
		rst_i = 1'b0;
		wait_ready(n);
		`CHK(n, 4099)
		`CHK(next_fetch_pointer_o, 16'hfeff)
		`CHK(push_pop_pointer_o, 16'h017f)
	endtask
	// Flag updates of the arithmetic and flag operations
	task automatic t_flags();
		op(CFS_OP_WR_A, 8'hff, 16'h0000);
		op(CFS_OP_ADD, 8'h01, 16'h0000);
		`CHK({acc_o, flag_word_o}, 16'h00fb)
		op(CFS_OP_CARRY_C, 8'h00, 16'h0000);
		`CHK(flag_word_o, 8'hfa)
		op(CFS_OP_CARRY_S, 8'h00, 16'h0000);
		`CHK(flag_word_o, 8'hfb)
		op(CFS_OP_MASK_C, 8'h00, 16'h0000);
		op(CFS_OP_RESULT, 8'h80, 16'h0000);
		`CHK({acc_o, flag_word_o}, 16'h80f5)
		op(CFS_OP_SHIFT, 8'h00, 16'h0000);
		`CHK({acc_o, flag_word_o}, 16'h00f2)
		op(CFS_OP_ADD, 8'h01, 16'h0000);
		`CHK({acc_o, flag_word_o}, 16'h01e0)
		op(CFS_OP_CARRY_S, 8'h00, 16'h0000);
		op(CFS_OP_ADC, 8'h0f, 16'h0000);
		`CHK({acc_o, flag_word_o}, 16'h11f0)
		op_carry_i = 1'b1;
		op(CFS_OP_BIT_BR, 8'h00, 16'h0000);
		op_carry_i = 1'b0;
		`CHK(flag_word_o, 8'hf1)
		op(CFS_OP_WR_CC, 8'h14, 16'h0000);
		`CHK(flag_word_o, 8'hf4)
	endtask
	// Masked request, unmask, entry, context and return
	task automatic t_irq();
		int n;
		op(CFS_OP_MASK_S, 8'h00, 16'h0000);
		@(negedge clock_i) irq_req_i = 8'h01;
		@(negedge clock_i) irq_req_i = 8'h00;
		instr_end_i = 1'b1;
		@(negedge clock_i) instr_end_i = 1'b0;
		`CHK({busy_o, irq_pend_o}, 9'h001)
		op(CFS_OP_WR_A, 8'h3c, 16'h0000);
		op(CFS_OP_WR_X, 8'h77, 16'h0000);
		op(CFS_OP_WR_Y, 8'h5a, 16'h0000);
		`CHK({acc_o, idx_x_o, idx_y_o}, 24'h3c775a)
		op(CFS_OP_MASK_C, 8'h00, 16'h0000);
		instr_end_i = 1'b1;
		@(negedge clock_i) instr_end_i = 1'b0;
		wait_ready(n);
		`CHK(push_pop_pointer_o, 16'h017a)
		`CHK(next_fetch_pointer_o, 16'hfafb)
		`CHK({flag_word_o[3], irq_pend_o, idx_y_o}, 17'h1005a)
		op(CFS_OP_WR_A, 8'h00, 16'h0000);
		op(CFS_OP_HANDLER_RETURN_OP, 8'h00, 16'h0000);
		wait_ready(n);
		`CHK({acc_o, idx_x_o, idx_y_o}, 24'h3c775a)
		`CHK({next_fetch_pointer_o, push_pop_pointer_o}, 32'hfeff017f)
		`CHK(flag_word_o, 8'hf4)
	endtask
	// Pointer load, call across the lower limit, return, restore
	task automatic t_stack();
		int n;
		op(CFS_OP_WR_SPL, 8'h01, 16'h0000);
		`CHK(push_pop_pointer_o, 16'h0101)
		op(CFS_OP_CALL, 8'h00, 16'h1234);
		wait_ready(n);
		`CHK({next_fetch_pointer_o, push_pop_pointer_o}, 32'h1234017f)
		op(CFS_OP_RET, 8'h00, 16'h0000);
		wait_ready(n);
		`CHK({next_fetch_pointer_o, push_pop_pointer_o}, 32'hfeff0101)
		op(CFS_OP_SP_RST, 8'h00, 16'h0000);
		`CHK(push_pop_pointer_o, 16'h017f)
		// Software break is taken although masked
		op(CFS_OP_MASK_S, 8'h00, 16'h0000);
		op(CFS_OP_TRAP, 8'h00, 16'h0000);
		wait_ready(n);
		`CHK({next_fetch_pointer_o, push_pop_pointer_o}, 32'hfcfd017a)
		op(CFS_OP_HANDLER_RETURN_OP, 8'h00, 16'h0000);
		wait_ready(n);
		`CHK({next_fetch_pointer_o, push_pop_pointer_o, flag_word_o}, 40'hfeff017ff4)
		op(CFS_OP_WR_PC, 8'h00, 16'h12fe);
		op(CFS_OP_INC_PC, 8'h00, 16'h0000);
		`CHK(next_fetch_pointer_o, 16'h12ff)
		// Clock enable low freezes the pointer load
		ce_i = 1'b0;
		op(CFS_OP_WR_SPL, 8'h22, 16'h0000);
		`CHK(push_pop_pointer_o, 16'h017f)
		ce_i = 1'b1;
	endtask
	// Reset sources: disabled undervoltage, then watchdog, undervoltage, pin
	task automatic t_sources();
		int n;
		@(negedge clock_i) {option_byte_i, uv_detect_i} = 9'h011;
		repeat (3) @(negedge clock_i);
		`CHK({busy_o, reset_pin_oe_o}, 2'b00)
		{option_byte_i, uv_detect_i} = 9'h000;
		for (int s = 0; s < 3; s++) begin
			op(CFS_OP_WR_A, 8'h11, 16'h0000);
			wdg_reset_i = (s == 0);
			uv_detect_i = (s == 1);
			reset_pin_i = (s != 2);
			repeat (2) @(negedge clock_i);
			`CHK({busy_o, reset_pin_oe_o}, {1'b1, s != 2})
			{wdg_reset_i, uv_detect_i, reset_pin_i} = 3'b001;
			wait_ready(n);
			`CHK({acc_o, next_fetch_pointer_o}, 24'h00feff)
		end
	endtask
	// Main sequence
	initial begin
		t_reset();
		t_flags();
		t_irq();
		t_stack();
		t_sources();
		stop_test();
	end
	// Watchdog against a hang
	initial begin
		#400000;
		error_cnt++;
		stop_test();
	end
endmodule
